// *** adc_spi_register_map.sv ***
// Register space of the converter behind its three-wire serial port:
// chip configuration, shadowed function registers with commit, and the
// feature register. Assumes all pins are synchronous to CLK_I.
`timescale 1ns/1ps
`default_nettype none
module adc_spi_register_map
    import adc_regmap_pkg::*;
#(
    parameter logic [7:0] CHIP_IDENTITY_VALUE = 8'hA5, // Arbitrary value
    parameter logic [1:0] SPEED_GRADE   = 2'h1
)(
    // Clock and reset
    input  wire logic    CLK_I,
    input  wire logic    SYS_RST_I,
    // Serial port pins
    input  wire logic    SCLK_I,
    input  wire logic    CHIP_SELECT_N_I,
    input  wire logic    SDIO_I,
    output logic         SDIO_O,
    output logic         SDIO_OE_O,
    // Active settings to the converter core
    output var config_t  CONFIG_O
);

    logic [7:0]        shadow [SHADOW_N];
    logic [7:0]        active [SHADOW_N];
    logic [7:0]        feature;
    logic              lsb_first;
    logic              commit_pend;
    wr_t               wr;
    logic [ADDR_W-1:0] rd_addr;
    logic [7:0]        rd_data;

    // Shadow window test, used by both the write and the read path
    function automatic logic in_shadow(input logic [12:0] a);
        in_shadow = (a >= ADDR_POWER) && (a <= ADDR_VREF); // R6
    endfunction

    function automatic logic [4:0] shadow_idx(input logic [12:0] a);
        logic [12:0] d;
        d = a - ADDR_POWER;
        shadow_idx = d[4:0];
    endfunction

    spi_frame_engine u_engine (
        .clk_i           (CLK_I),
        .rst_i           (SYS_RST_I),
        .sclk_i          (SCLK_I),
        .chip_select_n_i (CHIP_SELECT_N_I),
        .sdio_i          (SDIO_I),
        .sdio_o          (SDIO_O),
        .sdio_oe_o       (SDIO_OE_O),
        .lsb_first_i     (lsb_first),
        .rd_data_i       (rd_data),
        .rd_addr_o       (rd_addr),
        .wr_o            (wr)
    );

    // Write decode; masked bits are stored as their fixed value (zero, but one for power bit 7) whatever the host sends
    wire [7:0] wr_mask     = reg_mask(wr.addr);
    wire [7:0] wr_value    = (wr.data & wr_mask) | reg_fixed(wr.addr); // R2
    wire [4:0] wr_idx      = shadow_idx(wr.addr);
    wire       wr_shadow   = wr.valid && in_shadow(wr.addr)
                             && (wr_mask != 8'h00); // R6
    wire       wr_port     = wr.valid && (wr.addr == ADDR_PORT_CFG);
    wire       wr_feature  = wr.valid && (wr.addr == ADDR_FEATURE);
    wire       wr_commit   = wr.valid && (wr.addr == ADDR_COMMIT)
                             && wr.data[COMMIT_BIT]; // R7
    // Either mirrored soft reset bit acts, so bit order does not matter
    wire       soft_reset  = wr_port && (wr.data[PC_SRST_HI]
                             || wr.data[PC_SRST_LO]); // R16
    wire       any_reset   = SYS_RST_I || soft_reset;

    // Register storage; writes to identity and grade find no storage
    always_ff @(posedge CLK_I) begin
        if (any_reset) begin
            for (int i = 0; i < SHADOW_N; i++) begin
                shadow[i] <= reg_default(ADDR_POWER + 13'(i)); // R5
                active[i] <= reg_default(ADDR_POWER + 13'(i)); // R5
            end
            feature     <= RST_ZERO; // R5
            lsb_first   <= 1'b0; // R19
            commit_pend <= 1'b0;
        end else begin
            if (wr_shadow) begin
                shadow[wr_idx] <= wr_value; // R6
            end
            if (wr_port) begin
                lsb_first <= wr.data[PC_LSB_HI] || wr.data[PC_LSB_LO]; // R16
            end
            if (wr_feature) begin
                feature <= wr_value;
            end
            if (commit_pend) begin
                for (int i = 0; i < SHADOW_N; i++) begin
                    active[i] <= shadow[i]; // R7
                end
            end
            // Self-clearing; a new commit write in the same cycle re-arms
            commit_pend <= wr_commit; // R8
        end
    end

    // Read-back values; the commit byte always reads zero, even while a commit is pending
    wire [7:0] port_rd  = RST_PORT_CFG
                          | (8'(lsb_first) << PC_LSB_HI)
                          | (8'(lsb_first) << PC_LSB_LO); // R16
    wire [7:0] grade_rd = 8'(SPEED_GRADE) << GRADE_LSB; // R17
    wire       rd_shdw  = in_shadow(rd_addr);

    assign rd_data = (rd_addr == ADDR_PORT_CFG) ? port_rd
                   : (rd_addr == ADDR_CHIP_IDENTITY)  ? CHIP_IDENTITY_VALUE // R17
                   : (rd_addr == ADDR_GRADE)    ? grade_rd
                   : rd_shdw                    ? shadow[shadow_idx(rd_addr)]
                   : (rd_addr == ADDR_FEATURE)  ? feature
                   : 8'h00; // R2

    // Active bytes straight from their flip-flops
    assign CONFIG_O.power_modes      = active[shadow_idx(ADDR_POWER)];
    assign CONFIG_O.global_clock     = active[shadow_idx(ADDR_GCLK)];
    assign CONFIG_O.clock_divide     = active[shadow_idx(ADDR_CLKDIV)];
    assign CONFIG_O.test_mode        = active[shadow_idx(ADDR_TEST)];
    assign CONFIG_O.offset_adjust    = active[shadow_idx(ADDR_OFFSET)];
    assign CONFIG_O.output_mode      = active[shadow_idx(ADDR_OUT_MODE)];
    assign CONFIG_O.output_phase     = active[shadow_idx(ADDR_OUT_PHASE)];
    assign CONFIG_O.output_delay     = active[shadow_idx(ADDR_OUT_DELAY)];
    assign CONFIG_O.reference_select = active[shadow_idx(ADDR_VREF)];
    assign CONFIG_O.digital_feature  = feature; // R1

endmodule // adc_spi_register_map
`default_nettype wire

// *** adc_regmap_pkg.sv ***
// Constants, register layout and carrier types for the converter's serial
// register space. Assumes a single 100 MHz clock and a three-wire serial
// host whose pins are already synchronous to that clock.
//
// How it works
// R1 - Space splits into chip config, commit, shadowed function and feature.
// R2 - Unlisted addresses and bits hold nothing; they read as zero.
// R3 - Host writes zero into unused bits of a partly used byte.
// R4 - Host never writes an address whose whole byte is unused.
// R5 - Any reset reloads every register with its default value.
// R6 - Function registers 0x08 to 0x18 are written to shadow copies first.
// R7 - Writing 0x01 to 0xFF copies all shadows to active at once.
// R8 - The commit bit clears itself after the copy.
// R9 - Reference select resets to 0xC0, the 2.0 V p-p range.
// R10 - Host picks normal, full power-down or standby mode.
// R11 - Host sets stabilizer, divider ratio, divider phase and sync enable.
// R12 - Host sets a digital offset correction of the converter output.
// R13 - Host selects a test pattern replacing conversion data.
// R14 - Host picks output format and inverts the data clock polarity.
// R15 - Host adjusts the data clock output delay against the data.
// R16 - Port config mirrors nibbles, bits 4 and 3 read one, resets 0x18.
// R17 - Chip identity and speed grade are read only.
// R18 - Frame is 16-bit instruction, read/write first, then 8-bit words.
// R19 - Bit order defaults to MSB first, switchable in port config.
// R20 - Chip select low starts a frame; holding it low streams.
package adc_regmap_pkg;

    localparam int ADDR_W    = 13;
    localparam int BYTE_BITS = 8;
    localparam int INSTR_BITS = 16;

    // Register offsets
    localparam logic [12:0] ADDR_PORT_CFG   = 13'h0000;
    localparam logic [12:0] ADDR_CHIP_IDENTITY    = 13'h0001;
    localparam logic [12:0] ADDR_GRADE      = 13'h0002;
    localparam logic [12:0] ADDR_POWER      = 13'h0008;
    localparam logic [12:0] ADDR_GCLK       = 13'h0009;
    localparam logic [12:0] ADDR_CLKDIV     = 13'h000B;
    localparam logic [12:0] ADDR_TEST       = 13'h000D;
    localparam logic [12:0] ADDR_OFFSET     = 13'h0010;
    localparam logic [12:0] ADDR_OUT_MODE   = 13'h0014;
    localparam logic [12:0] ADDR_OUT_PHASE  = 13'h0016;
    localparam logic [12:0] ADDR_OUT_DELAY  = 13'h0017;
    localparam logic [12:0] ADDR_VREF       = 13'h0018;
    localparam logic [12:0] ADDR_COMMIT     = 13'h00FF;
    localparam logic [12:0] ADDR_FEATURE    = 13'h0100;
    localparam int          SHADOW_N        = 17;

    // Reset values
    localparam logic [7:0] RST_PORT_CFG  = 8'h18;
    localparam logic [7:0] RST_POWER     = 8'h80;
    localparam logic [7:0] RST_GCLK      = 8'h01;
    localparam logic [7:0] RST_VREF      = 8'hC0;
    localparam logic [7:0] RST_ZERO      = 8'h00;

    // Port configuration fields mirrored about the byte centre, then commit and grade bits
    localparam int PC_LSB_HI  = 6;
    localparam int PC_LSB_LO  = 1;
    localparam int PC_SRST_HI = 5;
    localparam int PC_SRST_LO = 2;
    localparam int COMMIT_BIT = 0;
    localparam int GRADE_LSB  = 4;

    // Instruction word fields
    localparam int          RW_BIT    = 15;
    localparam logic [1:0]  WC_STREAM = 2'h3;

    // One write taken from the serial port
    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } wr_t;

    // Active settings seen by the converter core
    typedef struct packed {
        logic [7:0] power_modes;
        logic [7:0] global_clock;
        logic [7:0] clock_divide;
        logic [7:0] test_mode;
        logic [7:0] offset_adjust;
        logic [7:0] output_mode;
        logic [7:0] output_phase;
        logic [7:0] output_delay;
        logic [7:0] reference_select;
        logic [7:0] digital_feature;
    } config_t;

    // Writable bits of each shadowed or feature register; zero marks none there
    function automatic logic [7:0] reg_mask(input logic [12:0] a);
        unique case (a)
            ADDR_POWER:     reg_mask = 8'h23; // R10
            ADDR_GCLK:      reg_mask = 8'h03; // R11
            ADDR_CLKDIV:    reg_mask = 8'h3F; // R11
            ADDR_TEST:      reg_mask = 8'h37; // R13
            ADDR_OFFSET:    reg_mask = 8'hFF; // R12
            ADDR_OUT_MODE:  reg_mask = 8'h07; // R14
            ADDR_OUT_PHASE: reg_mask = 8'h80; // R14
            ADDR_OUT_DELAY: reg_mask = 8'h87; // R15
            ADDR_VREF:      reg_mask = 8'hC0; // R9
            ADDR_FEATURE:   reg_mask = 8'h1F;
            default:        reg_mask = 8'h00; // R2
        endcase
    endfunction

    // Bits that always read one
    function automatic logic [7:0] reg_fixed(input logic [12:0] a);
        reg_fixed = (a == ADDR_POWER) ? RST_POWER : RST_ZERO;
    endfunction

    // Default after any reset
    function automatic logic [7:0] reg_default(input logic [12:0] a);
        unique case (a)
            ADDR_POWER: reg_default = RST_POWER;
            ADDR_GCLK:  reg_default = RST_GCLK;
            ADDR_VREF:  reg_default = RST_VREF; // R9
            default:    reg_default = RST_ZERO;
        endcase
    endfunction

endpackage

// *** spi_frame_engine.sv ***
// Serial frame engine of the three-wire port: instruction, data words,
// address stepping and read-back drive. Assumes serial clock, chip select
// and data pins are synchronous to CLK and slower than a quarter of it.
`timescale 1ns/1ps
`default_nettype none
module spi_frame_engine
    import adc_regmap_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Serial pins
    input  wire logic              sclk_i,
    input  wire logic              chip_select_n_i,
    input  wire logic              sdio_i,
    output logic                   sdio_o,
    output logic                   sdio_oe_o,
    // Register side
    input  wire logic              lsb_first_i,
    input  wire logic [7:0]        rd_data_i,
    output logic [ADDR_W-1:0]      rd_addr_o,
    output var wr_t                wr_o
);

    typedef enum logic [1:0] {S_INSTR, S_DATA, S_DONE} state_t;

    state_t              state;
    logic                sclk_q;
    logic [4:0]          cnt;
    logic [15:0]         instr;
    logic [7:0]          dshift;
    logic [7:0]          obyte;
    logic                is_read;
    logic [1:0]          wc;
    logic [1:0]          bytes;

    // Bit k of a byte as it leaves in the chosen order
    function automatic logic bit_of(input logic [7:0] b,
                                    input logic [2:0] k,
                                    input logic       lsb);
        bit_of = lsb ? b[k] : b[3'h7 - k];
    endfunction

    wire              rise        = sclk_i & ~sclk_q;
    wire              fall        = ~sclk_i & sclk_q;
    wire [15:0]       next_instr  = {instr[14:0], sdio_i};
    wire [7:0]        next_byte   = lsb_first_i ? {sdio_i, dshift[7:1]}
                                                : {dshift[6:0], sdio_i}; // R19
    // MSB-first frames walk down, LSB-first frames walk up
    wire [ADDR_W-1:0] next_addr   = lsb_first_i ? rd_addr_o + 13'h0001
                                                : rd_addr_o - 13'h0001;
    wire              last_byte   = (wc != WC_STREAM) && (bytes == wc);

    // Frame sequencer; chip select high aborts, so no stall between bytes
    always_ff @(posedge clk_i) begin
        sclk_q      <= sclk_i;
        wr_o.valid  <= 1'b0;
        if (rst_i || chip_select_n_i) begin
            state     <= S_INSTR; // R20
            cnt       <= 5'h00;
            sdio_oe_o <= 1'b0;
            sdio_o    <= 1'b0;
            instr     <= 16'h0000;
            dshift    <= 8'h00;
            obyte     <= 8'h00;
            is_read   <= 1'b0;
            wc        <= 2'h0;
            bytes     <= 2'h0;
            rd_addr_o <= 13'h0000;
            wr_o.addr <= 13'h0000;
            wr_o.data <= 8'h00;
        end else if (rise) begin
            unique case (state)
                S_INSTR: begin
                    instr <= next_instr;
                    cnt   <= cnt + 5'h01;
                    if (cnt == 5'(INSTR_BITS - 1)) begin
                        is_read   <= next_instr[RW_BIT]; // R18
                        wc        <= next_instr[14:13]; // R18
                        rd_addr_o <= next_instr[12:0];
                        bytes     <= 2'h0;
                        cnt       <= 5'h00;
                        state     <= S_DATA;
                    end
                end
                S_DATA: begin
                    dshift <= next_byte;
                    cnt    <= cnt + 5'h01;
                    if (cnt == 5'(BYTE_BITS - 1)) begin
                        cnt   <= 5'h00;
                        bytes <= bytes + 2'h1;
                        rd_addr_o <= next_addr;
                        if (!is_read) begin
                            wr_o <= '{valid: 1'b1, addr: rd_addr_o,
                                      data: next_byte}; // R18
                        end
                        if (last_byte) begin
                            state     <= S_DONE;
                            sdio_oe_o <= 1'b0;
                        end
                    end
                end
                S_DONE: begin
                    cnt <= 5'h00; // Extra clocks ignored until deselect
                end
            endcase
        end else if (fall && state == S_DATA && is_read) begin
            // Drive on the falling edge so the host samples on rising
            sdio_oe_o <= 1'b1;
            if (cnt == 5'h00) begin
                obyte  <= rd_data_i;
                sdio_o <= bit_of(rd_data_i, 3'h0, lsb_first_i);
            end else begin
                sdio_o <= bit_of(obyte, cnt[2:0], lsb_first_i);
            end
        end
    end

endmodule // spi_frame_engine
`default_nettype wire

// *** adc_spi_register_map_properties.sv ***
// Concurrent checks on the register map top ports.
// Assumes one clock domain and a synchronous active high reset.
`timescale 1ns/1ps
`default_nettype none
module adc_spi_register_map_properties
    import adc_regmap_pkg::*;
(
    // Watched ports
    input wire logic    CLK_I,
    input wire logic    SYS_RST_I,
    input wire logic    SCLK_I,
    input wire logic    CHIP_SELECT_N_I,
    input wire logic    SDIO_I,
    input wire logic    SDIO_O,
    input wire logic    SDIO_OE_O,
    input wire config_t CONFIG_O
);
    // Settings expected right after any reset
    localparam config_t DEF = '{power_modes: RST_POWER,
        global_clock: RST_GCLK, reference_select: RST_VREF,
        default: RST_ZERO};
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    reset_defaults_a: assert property (
        $fell(SYS_RST_I) |-> CONFIG_O == DEF) else $error("defaults lost");
    reset_quiet_a: assert property (
        $fell(SYS_RST_I) |-> !SDIO_OE_O && !SDIO_O) else $error("pin busy");
    // Six idle cycles cover the commit latency of the last byte
    shadow_hold_a: assert property (
        CHIP_SELECT_N_I [*6] |-> $stable(CONFIG_O)) else $error("drift");
    feature_cause_a: assert property (
        $changed(CONFIG_O.digital_feature) |-> !$past(CHIP_SELECT_N_I, 2))
        else $error("feature changed idle");
    oe_needs_cs_a: assert property (
        SDIO_OE_O |-> !$past(CHIP_SELECT_N_I)) else $error("drive idle");
    oe_rise_a: assert property (
        $rose(SDIO_OE_O) |-> !$past(SCLK_I)) else $error("drive on high");
    sdio_hold_a: assert property (
        SDIO_OE_O && $past(SDIO_OE_O) && $past(SCLK_I) && SCLK_I
        |-> $stable(SDIO_O)) else $error("read bit moved");
    masks_hold_a: assert property (
        CONFIG_O.power_modes[7] && CONFIG_O.reference_select[5:0] == 6'h00
        && CONFIG_O.digital_feature[7:5] == 3'h0) else $error("open bit");
endmodule // adc_spi_register_map_properties
bind adc_spi_register_map adc_spi_register_map_properties u_props (
    .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .SCLK_I(SCLK_I),
    .CHIP_SELECT_N_I(CHIP_SELECT_N_I), .SDIO_I(SDIO_I), .SDIO_O(SDIO_O),
    .SDIO_OE_O(SDIO_OE_O), .CONFIG_O(CONFIG_O));
`default_nettype wire

// *** spi_host_model.sv ***
// Serial host model for the three-wire port; also resolves the data wire.
// Assumes the device samples pins on CLK_I; each half bit is 4 clocks.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    // Clock
    input  wire logic CLK_I,
    // Serial pins
    output logic      SCLK_O,
    output logic      CHIP_SELECT_N_O,
    output logic      SDIO_WIRE_O,
    input  wire logic SDIO_DEV_I,
    input  wire logic SDIO_OE_I
);
    logic host_bit;
    logic drive;
    logic churn = 1'b0;
    initial begin
        {SCLK_O, host_bit, drive} = 3'h0;
        CHIP_SELECT_N_O = 1'b1;
    end
    // Released wire toggles so a stale bit never passes as read data
    always @(posedge CLK_I) churn <= ~churn;
    assign SDIO_WIRE_O = SDIO_OE_I ? SDIO_DEV_I : (drive ? host_bit : churn);
    task automatic half();
        repeat (4) @(posedge CLK_I);
        #1;
    endtask
    // Data set while clock low, wire sampled as clock rises
    task automatic bit_io(input logic b, output logic s);
        host_bit = b;
        half();
        s = SDIO_WIRE_O;
        SCLK_O = 1'b1;
        half();
        SCLK_O = 1'b0;
    endtask
    // Instruction MSB first, then n bytes in the chosen order
    task automatic frame(input logic rd, input logic [12:0] addr,
        input int n, input logic [15:0] wd, input logic lsb,
        output logic [15:0] rdata);
        logic [15:0] ins;
        logic [7:0]  b;
        logic        s;
        ins = {rd, 2'(n - 1), addr};
        rdata = 16'h0000;
        CHIP_SELECT_N_O = 1'b0;
        drive = 1'b1;
        for (int i = 15; i >= 0; i--) bit_io(ins[i], s);
        drive = !rd;
        for (int k = 0; k < n; k++) begin
            b = k ? wd[7:0] : wd[15:8];
            for (int i = 0; i < 8; i++) begin
                bit_io(b[lsb ? i : 7 - i], s);
                rdata[(k ? 0 : 8) + (lsb ? i : 7 - i)] = s;
            end
        end
        half();
        CHIP_SELECT_N_O = 1'b1;
        drive = 1'b0;
        half();
    endtask
endmodule // spi_host_model
`default_nettype wire

// *** adc_spi_register_map_tb.sv ***
// Self-checking bench: host model drives frames, a bench model predicts.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
`default_nettype none
module adc_spi_register_map_tb
    import adc_regmap_pkg::*;
;
    logic    clk = 1'b0;
    logic    rst = 1'b1;
    logic    sclk, cs_n, sdio, dout, oe;
    config_t cfg;
    int      bad_count, check_count;
    logic    lsb;
    logic [31:0] seed = 32'h65DB;
    logic [15:0] r;
    logic [7:0]  shd [10], act [10], v;
    int      adr [10] = '{8, 9, 11, 13, 16, 20, 22, 23, 24, 256};
    logic [7:0] msk [10] = '{8'h23, 8'h03, 8'h3F, 8'h37, 8'hFF, 8'h07,
        8'h80, 8'h87, 8'hC0, 8'h1F};
    always #5 clk = ~clk;
    adc_spi_register_map #(.CHIP_IDENTITY_VALUE(8'h3C), .SPEED_GRADE(2'h2)) dut (
        .CLK_I(clk), .SYS_RST_I(rst), .SCLK_I(sclk),
        .CHIP_SELECT_N_I(cs_n), .SDIO_I(sdio), .SDIO_O(dout),
        .SDIO_OE_O(oe), .CONFIG_O(cfg));
    spi_host_model host (.CLK_I(clk), .SCLK_O(sclk), .CHIP_SELECT_N_O(cs_n),
        .SDIO_WIRE_O(sdio), .SDIO_DEV_I(dout), .SDIO_OE_I(oe));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // Model's active bytes packed in the order of the design's carrier
    function automatic logic [79:0] model_cfg();
        logic [79:0] w;
        w = 80'h0;
        for (int i = 0; i < 10; i++) w[79 - 8 * i -: 8] = act[i];
        return w;
    endfunction
    task automatic model_reset();
        foreach (shd[i]) shd[i] = 8'h00;
        shd[0] = 8'h80;
        shd[1] = 8'h01;
        shd[8] = 8'hC0;
        act = shd;
        lsb = 1'b0;
    endtask
    task automatic check(input logic [79:0] got, input logic [79:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        host.frame(1'b0, a, 1, {d, 8'h00}, lsb, r);
    endtask
    task automatic rd(input logic [12:0] a, input logic [7:0] e);
        host.frame(1'b1, a, 1, 16'h0000, lsb, r);
        check(80'(r[15:8]), 80'(e));
    endtask
    // Random settings into every shadow; unused bits written as zero
    task automatic fill();
        for (int i = 0; i < 9; i++) begin
            v = rnd() & msk[i];
            wr(adr[i][12:0], v);
            shd[i] = v | (i == 0 ? 8'h80 : 8'h00);
        end
    endtask
    task automatic commit();
        wr(13'h00FF, 8'h01);
        for (int i = 0; i < 9; i++) act[i] = shd[i];
    endtask
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        final_report();
    end
    initial begin
        model_reset();
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        check(cfg, model_cfg());
        rd(13'h0000, 8'h18);
        rd(13'h0001, 8'h3C);
        wr(13'h0001, rnd());
        rd(13'h0001, 8'h3C);
        rd(13'h0002, 8'h20);
        rd(13'h0003, 8'h00);
        $display("test reset done");
        fill();
        check(cfg, model_cfg());
        for (int i = 0; i < 9; i++) rd(adr[i][12:0], shd[i]);
        commit();
        check(cfg, model_cfg());
        rd(13'h00FF, 8'h00);
        v = rnd() & msk[9];
        wr(13'h0100, v);
        shd[9] = v;
        act[9] = v;
        check(cfg, model_cfg());
        $display("test shadow done");
        shd[7] = rnd() & msk[7];
        shd[6] = rnd() & msk[6];
        host.frame(1'b0, 13'h0017, 2, {shd[7], shd[6]}, lsb, r);
        host.frame(1'b1, 13'h0017, 2, 16'h0000, lsb, r);
        check(80'(r), 80'({shd[7], shd[6]}));
        // A stuck commit bit would have copied the new shadows already
        check(cfg, model_cfg());
        commit();
        check(cfg, model_cfg());
        $display("test stream done");
        wr(13'h0000, 8'h42);
        lsb = 1'b1;
        rd(13'h0000, 8'h5A);
        shd[8] = 8'h40;
        wr(13'h0018, 8'h40);
        commit();
        check(cfg, model_cfg());
        wr(13'h0000, 8'h24);
        model_reset();
        check(cfg, model_cfg());
        rd(13'h0000, 8'h18);
        $display("test order done");
        fill();
        commit();
        @(posedge clk);
        #1 rst = 1'b1;
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        model_reset();
        check(cfg, model_cfg());
        rd(13'h0018, 8'hC0);
        $display("test reset again done");
        final_report();
    end
endmodule // adc_spi_register_map_tb
`default_nettype wire
